//--- bench/scirq_host_model.sv
`timescale 1ns/1ps
module scirq_host_model (
  input wire logic i_clk,
  input wire logic i_line_en,
  input wire logic i_irq,
  output int o_taken
);
  logic irq_r = 1'b0;
  initial o_taken = 0;
  // A level that stays high is taken once, as one pended entry
  always @(posedge i_clk) begin
    if (i_line_en && i_irq && !irq_r) o_taken <= o_taken + 1;
    irq_r <= i_irq;
  end
endmodule // scirq_host_model

//--- bench/scirq_properties.sv
`timescale 1ns/1ps
`include "scirq_defs.svh"
module scirq_props #(parameter int N_CTL = 2) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_awvalid,
  input wire logic i_wvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic i_rready,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic [N_CTL-1:0] o_irq_req,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_irq_or;
    o_irq == |o_irq_req;
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not OR");
  property p_b_after_w;
    i_ce && i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid;
  endproperty
  a_b_after_w: assert property (p_b_after_w) else $error("no bvalid");
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_after_ar;
    i_ce && i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_r_after_ar: assert property (p_r_after_ar) else $error("no rvalid");
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_ar_blocked;
    o_rvalid |-> !o_arready;
  endproperty
  a_ar_blocked: assert property (p_ar_blocked) else $error("arready high");
  property p_w_blocked;
    o_bvalid |-> !o_awready && !o_wready;
  endproperty
  a_w_blocked: assert property (p_w_blocked) else $error("wready high");
  property p_unmapped;
    i_ce && i_arvalid && o_arready && !(i_araddr inside {`SCIRQ_PEND1_ADDR,
      `SCIRQ_PEND2_ADDR, `SCIRQ_EN1_ADDR, `SCIRQ_EN2_ADDR,
      `SCIRQ_MODE1_ADDR, `SCIRQ_MODE2_ADDR})
      |=> o_rresp == `SCIRQ_RESP_SLVERR && o_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule // scirq_props
bind scirq_top scirq_props #(.N_CTL(N_CTL)) u_props (.*);

//--- bench/test_serial_ctrl_irq_config.sv
`timescale 1ns/1ps
`include "scirq_defs.svh"
module test_serial_ctrl_irq_config;
  import scirq_pkg::*;
  typedef struct {logic [14:0] en; logic [14:0] src; logic irq;} scirq_row_t;
  localparam logic [31:0] ADR [3][2] = '{
    '{`SCIRQ_PEND1_ADDR, `SCIRQ_PEND2_ADDR},
    '{`SCIRQ_EN1_ADDR, `SCIRQ_EN2_ADDR},
    '{`SCIRQ_MODE1_ADDR, `SCIRQ_MODE2_ADDR}};
  logic i_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0;
  logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0;
  logic [3:0] i_wstrb = 4'hF;
  scirq_src_t [1:0] i_src = '0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0] o_bresp, o_rresp, o_irq_req, rd_r, wr_b;
  logic [31:0] o_rdata, rd_d;
  int failures = 0, samples_checked = 0, taken;
  scirq_row_t rows [30];
  always #25 i_clk = ~i_clk;
  scirq_top #(.N_CTL(2)) uut (.*);
  scirq_host_model u_host (.i_clk(i_clk), .i_line_en(1'b1), .i_irq(o_irq),
    .o_taken(taken));
  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task end_sim;
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, d);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    wr_b = o_bresp;
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    rd_d = o_rdata;
    rd_r = o_rresp;
    i_rready <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int k = 2; k < 6; k++) begin
      rd(ADR[k/2][k%2]);
      chk("reset value", rd_d, 32'h0);
    end
    rd(32'h4000A850);
    chk("unmapped resp", 32'(rd_r), 32'(`SCIRQ_RESP_SLVERR));
    wr(32'h4000A850, 32'h1);
    chk("unmapped wresp", 32'(wr_b), 32'(`SCIRQ_RESP_SLVERR));
    for (int k = 0; k < 30; k++) begin
      rows[k].src = 15'h1 << (k % 15);
      rows[k].en = (k < 15) ? rows[k].src : ~rows[k].src;
      rows[k].irq = (k < 15);
    end
    // Masked rows still set pending; only the request must stay low
    for (int k = 0; k < 30; k++) begin
      wr(ADR[1][k%2], 32'(rows[k].en));
      chk("bresp", 32'(wr_b), 32'(`SCIRQ_RESP_OKAY));
      @(posedge i_clk);
      i_src[k%2] <= rows[k].src;
      @(posedge i_clk);
      i_src <= '0;
      @(posedge i_clk);
      chk("irq_req", 32'(o_irq_req[k%2]), 32'(rows[k].irq));
      chk("irq", 32'(o_irq), 32'(rows[k].irq));
      rd(ADR[0][k%2]);
      chk("pending", rd_d, 32'(rows[k].src));
      chk("irq after read", 32'(o_irq_req), 32'h0);
    end
    wr(ADR[1][0], 32'h0);
    for (int m = 1; m >= 0; m--) begin
      wr(ADR[2][0], m ? 32'h7 : 32'h0);
      rd(ADR[2][0]);
      chk("mode", rd_d, m ? 32'h7 : 32'h0);
      @(posedge i_clk);
      i_src[0] <= 15'h7;
      repeat (2) @(posedge i_clk);
      rd(ADR[0][0]);
      chk("first pending", rd_d, 32'h7);
      rd(ADR[0][0]);
      chk("held pending", rd_d, m ? 32'h7 : 32'h0);
      i_src[0] <= '0;
    end
    chk("host requests", 32'(taken), 32'd15);
    // Clock enable low: a strobe must not be seen
    wr(ADR[1][0], 32'h8);
    @(posedge i_clk);
    i_ce <= 1'b0;
    i_src[0] <= 15'h8;
    @(posedge i_clk);
    i_src[0] <= '0;
    @(posedge i_clk);
    i_ce <= 1'b1;
    @(posedge i_clk);
    chk("frozen irq", 32'(o_irq_req), 32'h0);
    rd(ADR[0][0]);
    chk("frozen pending", rd_d, 32'h0);
    @(posedge i_clk);
    i_src[0] <= 15'h18;
    @(posedge i_clk);
    i_src[0] <= '0;
    wr(ADR[0][0], 32'h8);
    rd(ADR[0][0]);
    chk("write clear", rd_d, 32'h10);
    wr(ADR[1][1], 32'h0);
    i_wstrb <= 4'h1;
    wr(ADR[1][1], 32'h7FFF);
    i_wstrb <= 4'hF;
    rd(ADR[1][1]);
    chk("byte lane", rd_d, 32'hFF);
    // Reset in mid-run with enables, modes and a flag all set
    wr(ADR[1][0], 32'h7FFF);
    wr(ADR[2][0], 32'h7);
    @(posedge i_clk);
    i_src[0] <= 15'h8;
    @(posedge i_clk);
    i_src[0] <= '0;
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("irq in reset", 32'(o_irq), 32'h0);
    i_rstn <= 1'b1;
    rd(ADR[1][0]);
    chk("enable after reset", rd_d, 32'h0);
    rd(ADR[2][0]);
    chk("mode after reset", rd_d, 32'h0);
    rd(ADR[0][0]);
    chk("pending after reset", rd_d, 32'h0);
    end_sim;
  end
  // Far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    end_sim;
  end
endmodule // test_serial_ctrl_irq_config

//--- rtl/scirq_defs.svh
`ifndef SCIRQ_DEFS_SVH
`define SCIRQ_DEFS_SVH

`define SCIRQ_NUM_CTL 2
`define SCIRQ_SRC_W 15
`define SCIRQ_SEL_W 3

`define SCIRQ_PEND1_ADDR 32'h4000A840
`define SCIRQ_PEND2_ADDR 32'h4000A844
`define SCIRQ_EN1_ADDR 32'h4000A848
`define SCIRQ_EN2_ADDR 32'h4000A84C
`define SCIRQ_MODE1_ADDR 32'h4000A854
`define SCIRQ_MODE2_ADDR 32'h4000A858

`define SCIRQ_EN_RST 15'h0000
`define SCIRQ_MODE_RST 3'h0

`define SCIRQ_BIT_RXVAL 0
`define SCIRQ_BIT_TXFREE 1
`define SCIRQ_BIT_TXIDLE 2

`define SCIRQ_RESP_OKAY 2'h0
`define SCIRQ_RESP_SLVERR 2'h2

`endif

//--- rtl/scirq_pkg.sv
package scirq_pkg;

  typedef enum logic [1:0] {
    RK_PEND = 2'b00,
    RK_EN = 2'b01,
    RK_MODE = 2'b10
  } scirq_kind_t;

  typedef struct packed {
    logic hit;
    logic ctl;
    scirq_kind_t kind;
  } scirq_sel_t;

  // Source vector, bit order matches the enable and pending registers
  typedef struct packed {
    logic uart_parity_err_src;
    logic uart_framing_err_src;
    logic tx_dma_b_unloaded_src;
    logic tx_dma_a_unloaded_src;
    logic rx_dma_b_unloaded_src;
    logic rx_dma_a_unloaded_src;
    logic twowire_noack_src;
    logic twowire_cmd_done_src;
    logic twowire_tx_done_src;
    logic twowire_rx_done_src;
    logic tx_underrun_src;
    logic rx_overrun_src;
    logic tx_drained_src;
    logic tx_space_src;
    logic rx_has_data_src;
  } scirq_src_t;

  typedef struct packed {
    logic [2:0] prev;
    logic [14:0] irq_enable_reg;
    logic [2:0] irq_trigger_mode_reg;
    logic [14:0] irq_pending_reg;
  } scirq_ctl_t;

endpackage

//--- rtl/scirq_top.sv
`timescale 1ns/1ps
`include "scirq_defs.svh"

// Functional notes
// [RL1] Enable bit 0 lets the receive-data pending flag raise the request.
// [RL2] Enable bit 1 gates the transmit-space pending flag.
// [RL3] Enable bit 2 gates the transmitter-drained pending flag.
// [RL4] Enable bit 3 gates the receive-overrun pending flag.
// [RL5] Enable bit 4 gates the transmit-underrun pending flag.
// [RL6] Enable bits 5 to 8 gate the four two-wire bus events.
// [RL7] Enable bits 9 to 12 gate the four DMA buffer-unloaded events.
// [RL8] Enable bits 13 and 14 gate UART framing and parity errors.
// [RL9] Mode bit 2 picks edge (0) or level (1) for transmitter drained.
// [RL10] Mode bit 1 picks edge (0) or level (1) for transmit space.
// [RL11] Mode bit 0 picks edge (0) or level (1) for receive data.
// [RL12] Enable and mode registers of each controller reset to zero.
// [RL13] A pending register holds one flag per source at enable positions.
// [RL14] Software enables sources here and then the top-level line outside.
// [RL15] Edge mode sets on a 0-to-1 status change, level mode while high.
// [RL16] A controller request is the OR of all enabled pending flags.
module scirq_top
  import scirq_pkg::*;
#(
  parameter int N_CTL = `SCIRQ_NUM_CTL
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire scirq_src_t [N_CTL-1:0] i_src,
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [N_CTL-1:0] o_irq_req,
  output logic o_irq
);

  if (N_CTL < 1 || N_CTL > 2) begin : g_bad_n_ctl
    $error("N_CTL must be 1 or 2");
  end

  if ($bits(scirq_src_t) != `SCIRQ_SRC_W) begin : g_bad_src_w
    $error("Source vector width disagrees with SCIRQ_SRC_W");
  end

  // The trigger-mode logic serves exactly three selectable sources
  if (`SCIRQ_SEL_W != 3) begin : g_bad_sel_w
    $error("SCIRQ_SEL_W must be 3");
  end

  typedef struct packed {
    scirq_ctl_t [N_CTL-1:0] ctl;
    logic [N_CTL-1:0] irq_req;
    logic irq;
    logic awready;
    logic wready;
    logic arready;
    logic have_aw;
    logic have_w;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } scirq_state_t;

  scirq_state_t st_r;
  scirq_state_t st_nxt;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_go;
  scirq_sel_t wsel;
  scirq_sel_t rsel;
  logic [14:0] src_lvl;
  logic [14:0] set_v;
  logic [14:0] clr_v;
  logic [14:0] rd_v;

  // Register decode, shared by the read and write paths
  function automatic scirq_sel_t dec_addr(input logic [31:0] a);
    scirq_sel_t s;
    s.hit = 1'b1;
    s.ctl = 1'b0;
    s.kind = RK_PEND;
    case (a)
      `SCIRQ_PEND1_ADDR: s.kind = RK_PEND;
      `SCIRQ_EN1_ADDR: s.kind = RK_EN;
      `SCIRQ_MODE1_ADDR: s.kind = RK_MODE;
      `SCIRQ_PEND2_ADDR: begin
        s.ctl = 1'b1;
        s.kind = RK_PEND;
      end
      `SCIRQ_EN2_ADDR: begin
        s.ctl = 1'b1;
        s.kind = RK_EN;
      end
      `SCIRQ_MODE2_ADDR: begin
        s.ctl = 1'b1;
        s.kind = RK_MODE;
      end
      default: s.hit = 1'b0;
    endcase
    // Second controller's addresses are holes when only one is built
    if (s.ctl && N_CTL < 2) begin
      s.hit = 1'b0;
    end
    return s;
  endfunction

  // Byte-lane merge of a 15-bit field held in the low two bytes
  function automatic logic [14:0] merge15(input logic [14:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] strb);
    logic [14:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = d[7:0];
    end
    if (strb[1]) begin
      v[14:8] = d[14:8];
    end
    return v;
  endfunction

  // Selectable sources: edge mode needs the level of the previous edge
  function automatic logic [2:0] trig3(input logic [2:0] lvl,
                                       input logic [2:0] prv,
                                       input logic [2:0] mode);
    logic [2:0] t;
    t[0] = mode[0] ? lvl[0] : (lvl[0] & ~prv[0]); // RL11
    t[1] = mode[1] ? lvl[1] : (lvl[1] & ~prv[1]); // RL10
    t[2] = mode[2] ? lvl[2] : (lvl[2] & ~prv[2]); // RL9
    return t;
  endfunction

  // A new event in the clearing cycle survives the clear, so software
  // that reads and then services never loses an event
  function automatic logic [14:0] pend_upd(input logic [14:0] old,
                                           input logic [14:0] clr,
                                           input logic [14:0] set);
    return (old & ~clr) | set;
  endfunction

  // Enable gating per source; a masked source still keeps its flag
  function automatic logic [14:0] gate15(input logic [14:0] pend,
                                         input logic [14:0] en);
    logic [14:0] g;
    g = '0;
    g[0] = pend[0] & en[0]; // RL1
    g[1] = pend[1] & en[1]; // RL2
    g[2] = pend[2] & en[2]; // RL3
    g[3] = pend[3] & en[3]; // RL4
    g[4] = pend[4] & en[4]; // RL5
    g[8:5] = pend[8:5] & en[8:5]; // RL6
    g[12:9] = pend[12:9] & en[12:9]; // RL7
    g[13] = pend[13] & en[13]; // RL8
    g[14] = pend[14] & en[14]; // RL8
    return g;
  endfunction

  always_comb begin
    st_nxt = st_r;
    src_lvl = '0;
    set_v = '0;
    clr_v = '0;
    rd_v = '0;

    aw_take = i_awvalid & st_r.awready;
    w_take = i_wvalid & st_r.wready;
    ar_take = i_arvalid & st_r.arready;

    // Address and data are taken independently, in either order
    if (aw_take) begin
      st_nxt.have_aw = 1'b1;
      st_nxt.awaddr = i_awaddr;
    end
    if (w_take) begin
      st_nxt.have_w = 1'b1;
      st_nxt.wdata = i_wdata;
      st_nxt.wstrb = i_wstrb;
    end
    // A write lands only once both halves are in and no response waits
    wr_go = st_nxt.have_aw & st_nxt.have_w & ~st_r.bvalid;
    wsel = dec_addr(st_nxt.awaddr);
    rsel = dec_addr(i_araddr);

    // Each controller is independent; only the bus decode is shared
    for (int c = 0; c < N_CTL; c++) begin
      src_lvl = i_src[c];
      // Sources 3 and up are event strobes: set while high
      set_v = src_lvl; // RL15
      set_v[2:0] = trig3(src_lvl[2:0], st_r.ctl[c].prev,
                         st_r.ctl[c].irq_trigger_mode_reg); // RL15
      st_nxt.ctl[c].prev = src_lvl[2:0];

      clr_v = '0;
      if (wr_go && wsel.hit && wsel.ctl == 1'(c)) begin
        unique case (wsel.kind)
          RK_EN: begin
            st_nxt.ctl[c].irq_enable_reg = merge15(
              st_r.ctl[c].irq_enable_reg, st_nxt.wdata, st_nxt.wstrb);
          end
          RK_MODE: begin
            if (st_nxt.wstrb[0]) begin
              st_nxt.ctl[c].irq_trigger_mode_reg = st_nxt.wdata[2:0];
            end
          end
          RK_PEND: begin
            // Write one to clear, as an alternative to the read clear
            clr_v = merge15('0, st_nxt.wdata, st_nxt.wstrb);
          end
          default: begin
          end
        endcase
      end
      if (ar_take && rsel.hit && rsel.ctl == 1'(c)
          && rsel.kind == RK_PEND) begin
        clr_v = '1;
      end
      st_nxt.ctl[c].irq_pending_reg =
        pend_upd(st_r.ctl[c].irq_pending_reg, clr_v, set_v); // RL13

      st_nxt.irq_req[c] = |gate15(st_nxt.ctl[c].irq_pending_reg,
                                  st_nxt.ctl[c].irq_enable_reg); // RL16
    end
    st_nxt.irq = |st_nxt.irq_req;

    // Write response
    if (wr_go) begin
      st_nxt.have_aw = 1'b0;
      st_nxt.have_w = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wsel.hit ? `SCIRQ_RESP_OKAY : `SCIRQ_RESP_SLVERR;
    end else if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Readies stay low while a response waits: one write open at a time
    st_nxt.awready = ~st_nxt.have_aw & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.have_w & ~st_nxt.bvalid;

    // Read returns the value before any read clear takes effect
    if (ar_take) begin
      unique case (rsel.kind)
        RK_EN: rd_v = st_r.ctl[rsel.ctl].irq_enable_reg;
        RK_MODE: rd_v = {12'h000, st_r.ctl[rsel.ctl].irq_trigger_mode_reg};
        RK_PEND: rd_v = st_r.ctl[rsel.ctl].irq_pending_reg;
        default: rd_v = '0;
      endcase
      if (!rsel.hit) begin
        rd_v = '0;
      end
      st_nxt.rdata = {17'h00000, rd_v};
      st_nxt.rresp = rsel.hit ? `SCIRQ_RESP_OKAY : `SCIRQ_RESP_SLVERR;
      st_nxt.rvalid = 1'b1;
    end else if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // The next read is refused until this read data is taken
    st_nxt.arready = ~st_nxt.rvalid;
  end

  // Everything resets to zero: registers masked and edge mode
  always_ff @(posedge i_clk) begin
    // Reset acts even while the clock enable is low
    if (!i_rstn) begin
      st_r <= '0; // RL12
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_awready = st_r.awready;
  assign o_wready = st_r.wready;
  assign o_bresp = st_r.bresp;
  assign o_bvalid = st_r.bvalid;
  assign o_arready = st_r.arready;
  assign o_rdata = st_r.rdata;
  assign o_rresp = st_r.rresp;
  assign o_rvalid = st_r.rvalid;
  // One request line per controller, each straight from its flip-flop
  for (genvar gi = 0; gi < N_CTL; gi++) begin : g_req_out
    assign o_irq_req[gi] = st_r.irq_req[gi];
  end
  assign o_irq = st_r.irq;

endmodule // scirq_top
